// ==== rtl/cob_pkg.sv ====
/*
 * Constants and carrier types for the charger option upper byte.
 * Assumes a byte-wide register port driven by the device's serial register engine.
 */
package cob_pkg;

    // Register index of the upper option byte.
    localparam logic [7:0] CFG_ADDR = 8'h31;

    // Field positions within the byte.
    localparam int BIT_MON_BUF = 7;
    localparam int BIT_THROTTLE = 6;
    localparam int BIT_SYSMON_HI = 5;
    localparam int BIT_SYSMON_LO = 4;
    localparam int BIT_IN_SHUNT = 3;
    localparam int BIT_CHG_SHUNT = 2;
    localparam int BIT_GAIN = 1;
    localparam int BIT_FAST = 0;

    // Power-on value: monitor field off, both shunts 5 mOhm, high gain, fast loop on.
    localparam logic [7:0] CFG_RESET = 8'h3f;

    // System-power monitor field encodings.
    localparam logic [1:0] SYSMON_IN_PLUS_BAT = 2'h0;
    localparam logic [1:0] SYSMON_IN_ONLY = 2'h1;
    localparam logic [1:0] SYSMON_RESERVED = 2'h2;
    localparam logic [1:0] SYSMON_OFF = 2'h3;

    // Host input-current limit, in milliamps.
    localparam int ILIM_W = 14;
    localparam logic [13:0] ILIM_MAX_SLOW_MA = 14'h2710;
    localparam logic [13:0] ILIM_MAX_FAST_MA = 14'h1900;
    localparam logic [13:0] ILIM_RESET_MA = 14'h0000;

    // Fields of the option byte, most significant first.
    typedef struct packed {
        logic mon_buf_en;
        logic throttle_en;
        logic [1:0] sysmon_cfg;
        logic in_shunt_5m;
        logic chg_shunt_5m;
        logic gain_high;
        logic fast_en;
    } cob_cfg_t;

endpackage

// ==== rtl/cob_pin_sync.sv ====
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes asynchronous pin levels and the single system clock.
 */
`timescale 1ns/100ps
`default_nettype none

module cob_pin_sync #(
    parameter int W = 2
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level
);

    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;
    logic [W-1:0] stage3_reg;

    // The first stage feeds only the second, so metastability never reaches logic.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // A bit changes only once the second and third stages agree on it.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            level <= '0;
        end else begin
            level <= (stage2_reg & stage3_reg) | (level & (stage2_reg | stage3_reg));
        end
    end

endmodule // cob_pin_sync

`default_nettype wire

// ==== rtl/cob_option_byte.sv ====
/*
 * Upper charger option byte: storage, read-back and the controls it steers.
 * Assumes a byte register port on the system clock and two asynchronous status pins.
 */
`timescale 1ns/100ps
`default_nettype none

module cob_option_byte (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wr_data,
    input wire logic low_power_select,
    input wire logic ilim_wr,
    input wire logic [13:0] ilim_wr_ma,
    input wire logic adapter_present_pin,
    input wire logic adapter_config_below_160k_pin,
    output logic [7:0] reg_rd_data,
    output logic current_monitor_buffer_on,
    output logic lowpower_throttle_alert_on,
    output logic sysmon_sense_on,
    output logic sysmon_include_battery,
    output logic sysmon_gain_high,
    output logic input_shunt_5m,
    output logic charge_shunt_5m,
    output logic fast_comp_active,
    output logic [13:0] host_input_current_limit_ma,
    output logic ilim_write_ignored
);

    cob_pkg::cob_cfg_t cfg_reg;
    logic [1:0] pins_sync;
    logic adapter_present;
    logic cfg_below_160k;
    logic cfg_hit;
    logic [13:0] ilim_ceiling;

    // Pins arrive from outside the clock domain.
    cob_pin_sync #(
        .W(2)
    ) u_pin_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in({adapter_present_pin, adapter_config_below_160k_pin}),
        .level(pins_sync)
    );

    assign adapter_present = pins_sync[1];
    assign cfg_below_160k = pins_sync[0];
    assign cfg_hit = reg_wr && (reg_addr == cob_pkg::CFG_ADDR);

    // Picks the accepted limit ceiling from the fast compensation bit.
    function automatic logic [13:0] ceiling_for(input logic fast);
        ceiling_for = fast ? cob_pkg::ILIM_MAX_FAST_MA : cob_pkg::ILIM_MAX_SLOW_MA;
    endfunction

    assign ilim_ceiling = ceiling_for(cfg_reg.fast_en);

    // Option byte storage; writes are the only thing that moves it.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_reg <= cob_pkg::CFG_RESET;
        end else if (cfg_hit) begin
            cfg_reg <= reg_wr_data;
        end
    end

    // Read-back is registered; any other index reads as zero.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rd_data <= 8'h00;
        end else if (reg_addr == cob_pkg::CFG_ADDR) begin
            reg_rd_data <= cfg_reg;
        end else begin
            reg_rd_data <= 8'h00;
        end
    end

    // Monitor buffers. Low power overrides the enables to save quiescent current.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            current_monitor_buffer_on <= 1'b0;
            sysmon_sense_on <= 1'b0;
            sysmon_include_battery <= 1'b0;
            sysmon_gain_high <= 1'b1;
        end else begin
            current_monitor_buffer_on <= cfg_reg.mon_buf_en && !low_power_select;
            // The reserved code is treated as off so it never powers the sense path.
            sysmon_sense_on <= !low_power_select &&
                ((cfg_reg.sysmon_cfg == cob_pkg::SYSMON_IN_PLUS_BAT) ||
                 (cfg_reg.sysmon_cfg == cob_pkg::SYSMON_IN_ONLY));
            sysmon_include_battery <= !low_power_select &&
                (cfg_reg.sysmon_cfg == cob_pkg::SYSMON_IN_PLUS_BAT);
            sysmon_gain_high <= cfg_reg.gain_high;
        end
    end

    // Throttle alert only in battery-only low power; adapter presence gates it
    // as a guard even though the host is expected not to set it then.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            lowpower_throttle_alert_on <= 1'b0;
        end else begin
            lowpower_throttle_alert_on <= cfg_reg.throttle_en && low_power_select &&
                !adapter_present;
        end
    end

    // Shunt declarations and fast loop qualification.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            input_shunt_5m <= 1'b1;
            charge_shunt_5m <= 1'b1;
            fast_comp_active <= 1'b0;
        end else begin
            input_shunt_5m <= cfg_reg.in_shunt_5m;
            charge_shunt_5m <= cfg_reg.chg_shunt_5m;
            fast_comp_active <= cfg_reg.fast_en && cfg_reg.in_shunt_5m &&
                cfg_below_160k;
        end
    end

    // Host input-current limit. Over-ceiling writes leave the old value; turning
    // fast compensation on pulls a larger held value down to its ceiling.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            host_input_current_limit_ma <= cob_pkg::ILIM_RESET_MA;
            ilim_write_ignored <= 1'b0;
        end else begin
            ilim_write_ignored <= ilim_wr && (ilim_wr_ma > ilim_ceiling);
            if (ilim_wr && (ilim_wr_ma <= ilim_ceiling)) begin
                host_input_current_limit_ma <= ilim_wr_ma;
            end else if (host_input_current_limit_ma > ilim_ceiling) begin
                host_input_current_limit_ma <= ilim_ceiling;
            end
        end
    end

    a_cfg_write_lands: assert property (@(posedge clock) disable iff (sys_rst)
        cfg_hit |=> (cfg_reg == $past(reg_wr_data)))
        else $error("option byte did not take the written value");

    a_cfg_holds_still: assert property (@(posedge clock) disable iff (sys_rst)
        !cfg_hit |=> $stable(cfg_reg))
        else $error("option byte changed without a write");

    a_monbuf_low_power: assert property (@(posedge clock) disable iff (sys_rst)
        low_power_select |=> !current_monitor_buffer_on)
        else $error("current monitor buffer on in low power");

    a_monbuf_follows_bit: assert property (@(posedge clock) disable iff (sys_rst)
        (!low_power_select && cfg_reg.mon_buf_en) |=> current_monitor_buffer_on)
        else $error("current monitor buffer not on when enabled");

    a_sysmon_off_cases: assert property (@(posedge clock) disable iff (sys_rst)
        (low_power_select || cfg_reg.sysmon_cfg == cob_pkg::SYSMON_OFF) |=> !sysmon_sense_on)
        else $error("system power monitor on while it must be off");

    a_sysmon_battery: assert property (@(posedge clock) disable iff (sys_rst)
        sysmon_include_battery |-> sysmon_sense_on &&
            $past(cfg_reg.sysmon_cfg) == cob_pkg::SYSMON_IN_PLUS_BAT)
        else $error("battery power included without its mode");

    a_fast_qualified: assert property (@(posedge clock) disable iff (sys_rst)
        fast_comp_active |-> $past(cfg_below_160k) && $past(cfg_reg.in_shunt_5m) &&
            $past(cfg_reg.fast_en))
        else $error("fast compensation active without its conditions");

    a_ilim_reject: assert property (@(posedge clock) disable iff (sys_rst)
        (ilim_wr && ilim_wr_ma > ilim_ceiling) |=>
            ilim_write_ignored && host_input_current_limit_ma <= $past(ilim_ceiling))
        else $error("over-ceiling limit write was not ignored");

    a_ilim_accept: assert property (@(posedge clock) disable iff (sys_rst)
        (ilim_wr && ilim_wr_ma <= ilim_ceiling) |=>
            host_input_current_limit_ma == $past(ilim_wr_ma) && !ilim_write_ignored)
        else $error("in-range limit write was not taken");

    a_ilim_fast_clamp: assert property (@(posedge clock) disable iff (sys_rst)
        ($past(cfg_reg.fast_en) && cfg_reg.fast_en) |->
            host_input_current_limit_ma <= cob_pkg::ILIM_MAX_FAST_MA)
        else $error("limit above 6.4 A with fast compensation on");

    // Read-back mirrors the stored byte. The reset term skips the edge on which
    // the read-back register was still forced to zero by reset.
    a_rd_data_view: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_addr == cob_pkg::CFG_ADDR) |=>
            $past(sys_rst) || (reg_rd_data == $past(cfg_reg)))
        else $error("read-back does not show the option byte");

    // Any other index reads as zero, so a stray host read never sees this byte.
    a_rd_other_zero: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_addr != cob_pkg::CFG_ADDR) |=> (reg_rd_data == 8'h00))
        else $error("read-back not zero for another index");

    // A write aimed at another index must leave the byte alone.
    a_cfg_other_index: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_wr && reg_addr != cob_pkg::CFG_ADDR) |=> $stable(cfg_reg))
        else $error("write to another index changed the option byte");

    // The alert may only rise when low power and its enable stood one cycle before.
    a_alert_needs_mode: assert property (@(posedge clock) disable iff (sys_rst)
        lowpower_throttle_alert_on |-> $past(low_power_select) && $past(cfg_reg.throttle_en))
        else $error("throttle alert on without low power and its enable");

    // With battery only and low power, a set enable must turn the alert on.
    a_alert_follows_bit: assert property (@(posedge clock) disable iff (sys_rst)
        (cfg_reg.throttle_en && low_power_select && !adapter_present) |=>
            lowpower_throttle_alert_on)
        else $error("throttle alert not on when enabled in battery-only low power");

    // The adapter guard keeps the alert off even if the host set the enable anyway.
    a_alert_adapter_gate: assert property (@(posedge clock) disable iff (sys_rst)
        adapter_present |=> !lowpower_throttle_alert_on)
        else $error("throttle alert on with an adapter present");

    // The shunt and gain declarations are plain copies, one cycle behind the byte.
    a_in_shunt_copy: assert property (@(posedge clock) disable iff (sys_rst)
        1'b1 |=> (input_shunt_5m == $past(cfg_reg.in_shunt_5m)))
        else $error("input shunt declaration does not follow bit 3");

    // A wrong charge shunt declaration would scale charge current by two.
    a_chg_shunt_copy: assert property (@(posedge clock) disable iff (sys_rst)
        1'b1 |=> (charge_shunt_5m == $past(cfg_reg.chg_shunt_5m)))
        else $error("charge shunt declaration does not follow bit 2");

    // The gain select must track bit 1 whatever the monitor mode is.
    a_gain_copy: assert property (@(posedge clock) disable iff (sys_rst)
        1'b1 |=> (sysmon_gain_high == $past(cfg_reg.gain_high)))
        else $error("monitor gain does not follow bit 1");

    // Fast compensation is meaningless with the 10 mOhm input shunt.
    a_fast_needs_shunt: assert property (@(posedge clock) disable iff (sys_rst)
        !cfg_reg.in_shunt_5m |=> !fast_comp_active)
        else $error("fast compensation active with the 10 mOhm input shunt");

    // Clearing bit 0 must drop fast compensation on the next cycle.
    a_fast_needs_bit: assert property (@(posedge clock) disable iff (sys_rst)
        !cfg_reg.fast_en |=> !fast_comp_active)
        else $error("fast compensation active with its bit clear");

    // With every condition met, fast compensation must actually engage.
    a_fast_follows_all: assert property (@(posedge clock) disable iff (sys_rst)
        (cfg_reg.fast_en && cfg_reg.in_shunt_5m && cfg_below_160k) |=> fast_comp_active)
        else $error("fast compensation not active with all conditions met");

    // A high adapter config resistor must veto fast compensation.
    a_fast_pin_gate: assert property (@(posedge clock) disable iff (sys_rst)
        !cfg_below_160k |=> !fast_comp_active)
        else $error("fast compensation active with the config resistor too high");

    // Both live monitor codes must power the sense path outside low power.
    a_sysmon_on_modes: assert property (@(posedge clock) disable iff (sys_rst)
        (!low_power_select && (cfg_reg.sysmon_cfg == cob_pkg::SYSMON_IN_PLUS_BAT ||
            cfg_reg.sysmon_cfg == cob_pkg::SYSMON_IN_ONLY)) |=> sysmon_sense_on)
        else $error("system power monitor off in a live mode");

    // The reserved code must never power the sense path.
    a_sysmon_reserved_off: assert property (@(posedge clock) disable iff (sys_rst)
        (cfg_reg.sysmon_cfg == cob_pkg::SYSMON_RESERVED) |=> !sysmon_sense_on)
        else $error("system power monitor on for the reserved code");

    // Input-only mode must leave battery power out of the sum.
    a_sysmon_input_only: assert property (@(posedge clock) disable iff (sys_rst)
        (cfg_reg.sysmon_cfg == cob_pkg::SYSMON_IN_ONLY) |=> !sysmon_include_battery)
        else $error("battery power included in input-only mode");

    // Low power shuts the battery term as well as the sense path.
    a_sysmon_lp_battery: assert property (@(posedge clock) disable iff (sys_rst)
        low_power_select |=> !sysmon_include_battery)
        else $error("battery power included in low power");

    // No path may ever hold a limit above the 10 A ceiling.
    a_ilim_slow_ceiling: assert property (@(posedge clock) disable iff (sys_rst)
        host_input_current_limit_ma <= cob_pkg::ILIM_MAX_SLOW_MA)
        else $error("limit above 10 A");

    // The refusal pulse only ever answers a limit write.
    a_ilim_ignored_pulse: assert property (@(posedge clock) disable iff (sys_rst)
        ilim_write_ignored |-> $past(ilim_wr))
        else $error("limit refusal pulse without a limit write");

    // Without a write and within the ceiling, the limit must not drift.
    a_ilim_holds_still: assert property (@(posedge clock) disable iff (sys_rst)
        (!ilim_wr && host_input_current_limit_ma <= ilim_ceiling) |=>
            $stable(host_input_current_limit_ma))
        else $error("limit changed without a write");

endmodule // cob_option_byte

`default_nettype wire

// ==== verif/cob_host_model.sv ====
/* Host model driving the option byte register port and the limit port.
   Assumes one bench process calls its tasks and that clock is the system clock. */
`timescale 1ns/100ps
`default_nettype none

module cob_host_model (
    input wire logic clock,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wr_data,
    output logic ilim_wr,
    output logic [13:0] ilim_wr_ma
);
    // Idle levels from time zero so nothing is taken before the first request.
    initial begin
        reg_addr = 8'h31;
        reg_wr = 1'b0;
        reg_wr_data = 8'h00;
        ilim_wr = 1'b0;
        ilim_wr_ma = 14'h0000;
    end

    // One strobe per call; data is inverted once unqualified so stale values never help.
    task automatic put_byte(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock);
        reg_addr <= addr;
        reg_wr <= 1'b1;
        reg_wr_data <= data;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_addr <= 8'h31;
        reg_wr_data <= ~data;
    endtask

    // One limit word per call, scrambled after the taking edge.
    task automatic put_limit(input logic [13:0] ma);
        @(posedge clock);
        ilim_wr <= 1'b1;
        ilim_wr_ma <= ma;
        @(posedge clock);
        ilim_wr <= 1'b0;
        ilim_wr_ma <= ~ma;
    endtask
endmodule // cob_host_model

`default_nettype wire

// ==== verif/tb_top.sv ====
/* Self-checking bench for the option byte against an integer model.
   Assumes the host model drives the register and limit ports. */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic clock, sys_rst, low_power_select, adp, below;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
    logic reg_wr, ilim_wr, mon, alert, sense, incl, gain, ish, csh, fast, ign;
    logic [13:0] ilim_wr_ma, lim;
    logic [31:0] r;
    int failures, checked, m_cfg, m_lim;
    int lims[5] = '{6400, 6401, 10000, 10001, 9000};

    cob_host_model host_u (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wr_data(reg_wr_data), .ilim_wr(ilim_wr), .ilim_wr_ma(ilim_wr_ma));

    cob_option_byte dut_u (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wr_data(reg_wr_data), .low_power_select(low_power_select),
        .ilim_wr(ilim_wr), .ilim_wr_ma(ilim_wr_ma), .adapter_present_pin(adp),
        .adapter_config_below_160k_pin(below), .reg_rd_data(reg_rd_data),
        .current_monitor_buffer_on(mon), .lowpower_throttle_alert_on(alert),
        .sysmon_sense_on(sense), .sysmon_include_battery(incl), .sysmon_gain_high(gain),
        .input_shunt_5m(ish), .charge_shunt_5m(csh), .fast_comp_active(fast),
        .host_input_current_limit_ma(lim), .ilim_write_ignored(ign));

    // Free-running 10 MHz clock.
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk(input string what, input logic [13:0] seen, input logic [13:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Lets the store and read-back edges land, then compares every output except the refusal pulse with the model.
    task automatic settle();
        logic [7:0] b;
        repeat (2) @(posedge clock);
        #1;
        b = m_cfg[7:0];
        chk("read back", reg_rd_data, b);
        chk("mon buffer", mon, b[7] & ~low_power_select);
        chk("alert", alert, b[6] & low_power_select & ~adp);
        chk("sense", sense, (b[5:4] < 2'h2) & ~low_power_select);
        chk("include", incl, (b[5:4] == 2'h0) & ~low_power_select);
        chk("gain", gain, b[1]);
        chk("in shunt", ish, b[3]);
        chk("chg shunt", csh, b[2]);
        chk("fast", fast, b[0] & b[3] & below);
        chk("limit", lim, m_lim[13:0]);
    endtask

    // Only index 0x31 changes the model; a fast-loop setting pulls a high limit down.
    task automatic wr_cfg(input logic [7:0] addr, input logic [7:0] data);
        host_u.put_byte(addr, data);
        if (addr == 8'h31) m_cfg = data;
        if (m_cfg[0] && m_lim > 6400) m_lim = 6400;
        settle();
    endtask

    task automatic wr_lim(input int v);
        int ceil_ma;
        ceil_ma = m_cfg[0] ? 6400 : 10000;
        host_u.put_limit(v[13:0]);
        #1;
        chk("ignored", ign, v > ceil_ma);
        if (v <= ceil_ma) m_lim = v;
        chk("limit", lim, m_lim[13:0]);
    endtask

    // Hang guard: a stuck run ends as a failure.
    initial begin
        #1000000;
        failures++;
        close_out();
    end

    // Main sequence: reset, random bytes, limit ceilings, unmapped write, second reset.
    initial begin
        sys_rst = 1'b1;
        low_power_select = 1'b0;
        adp = 1'b0;
        below = 1'b0;
        void'($urandom(32'h5a61f013));
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        m_cfg = 8'h3f;
        m_lim = 0;
        repeat (3) @(posedge clock);
        settle();
        for (int i = 0; i < 24; i++) begin
            r = $urandom;
            @(posedge clock);
            low_power_select <= r[8];
            adp <= r[9];
            below <= r[10];
            repeat (5) @(posedge clock);
            wr_cfg(8'h31, {r[7], r[6] & ~r[9], i[1:0], r[3:0]});
        end
        for (int f = 0; f < 2; f++) begin
            wr_cfg(8'h31, {7'h04, f[0]});
            foreach (lims[k]) wr_lim(lims[k]);
        end
        wr_cfg(8'h31, 8'h09);
        wr_cfg(8'h30, 8'hf6);
        @(posedge clock);
        sys_rst <= 1'b1;
        @(posedge clock);
        sys_rst <= 1'b0;
        m_cfg = 8'h3f;
        m_lim = 0;
        repeat (3) @(posedge clock);
        settle();
        close_out();
    end
endmodule // tb_top

`default_nettype wire
